/* File: hw/tbc_core.sv */
/*
  16-bit timer/counter core with byte-wide register access over
  AXI4-Lite: counter, two double-buffered compares, capture, shared
  high-byte staging, clock select, flags and masks, waveform outputs.
  Assumes one 40 MHz clock and a master that keeps byte ordering.
*/
// The AXI4-Lite interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module tbc_core (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        extCountPin,
  input  wire logic        capturePin,
  input  wire logic        comparatorOut,
  input  wire logic        captureFromComparator,
  output logic             compareOutA,
  output logic             compareOutB,
  output logic [3:0]       irqReq,
  output logic             countFloor,
  output logic             countMax,
  output logic             countTop
);

  tbc_pkg::tbc_state_t  s_r;
  tbc_pkg::tbc_state_t  s_nxt;
  tbc_pkg::tbc_mode_t   mode;
  tbc_pkg::tbc_clksel_t clkSel;
  logic [15:0]          top;
  logic                 pwm;
  logic                 capIsTop;
  logic                 tick;
  logic                 wrap;
  logic                 matchA;
  logic                 matchB;
  logic                 extRise;
  logic                 extFall;
  logic                 pinCap;
  logic                 cmpCap;
  logic                 capEvent;
  logic                 wrGo;
  logic                 rdGo;
  logic [7:0]           wByte;
  logic [7:0]           rByte;
  logic                 rHit;
  logic                 wHit;

  // external count pin: one front end per edge keeps the module simple
  tbc_pin_edge u_extRise (
    .clk       (clk),
    .reset_n   (reset_n),
    .pinIn     (extCountPin),
    .filterEn  (1'b0),
    .riseSel   (1'b1),
    .edgePulse (extRise)
  );

  tbc_pin_edge u_extFall (
    .clk       (clk),
    .reset_n   (reset_n),
    .pinIn     (extCountPin),
    .filterEn  (1'b0),
    .riseSel   (1'b0),
    .edgePulse (extFall)
  );

  // capture sources, each synchronised and filtered on its own
  tbc_pin_edge u_capPin (
    .clk       (clk),
    .reset_n   (reset_n),
    .pinIn     (capturePin),
    .filterEn  (s_r.ctrlB[`TBC_B_CAP_FILTER]),
    .riseSel   (s_r.ctrlB[`TBC_B_CAP_RISE]),
    .edgePulse (pinCap)
  );

  tbc_pin_edge u_capCmp (
    .clk       (clk),
    .reset_n   (reset_n),
    .pinIn     (comparatorOut),
    .filterEn  (s_r.ctrlB[`TBC_B_CAP_FILTER]),
    .riseSel   (s_r.ctrlB[`TBC_B_CAP_RISE]),
    .edgePulse (cmpCap)
  );

  // mode decode, ceiling and tick selection
  always_comb begin
    mode     = tbc_pkg::tbc_mode_t'({s_r.ctrlB[`TBC_B_MODE_HI], s_r.ctrlA[`TBC_A_MODE_LO]});
    clkSel   = tbc_pkg::tbc_clksel_t'(s_r.ctrlB[`TBC_B_CLK_SEL]);
    pwm      = 1'b0;
    capIsTop = 1'b0;
    case (mode)
      tbc_pkg::TBC_M_PWM8, tbc_pkg::TBC_M_FPWM8: begin
        top = `TBC_TOP_8BIT;
        pwm = 1'b1;
      end
      tbc_pkg::TBC_M_PWM9, tbc_pkg::TBC_M_FPWM9: begin
        top = `TBC_TOP_9BIT;
        pwm = 1'b1;
      end
      tbc_pkg::TBC_M_PWM10, tbc_pkg::TBC_M_FPWM10: begin
        top = `TBC_TOP_10BIT;
        pwm = 1'b1;
      end
      tbc_pkg::TBC_M_CTC_A: begin
        top = s_r.cmpA;
      end
      tbc_pkg::TBC_M_CTC_CAP: begin
        top      = s_r.capture;
        capIsTop = 1'b1;
      end
      tbc_pkg::TBC_M_FPWM_CAP: begin
        top      = s_r.capture;
        capIsTop = 1'b1;
        pwm      = 1'b1;
      end
      tbc_pkg::TBC_M_FPWM_A: begin
        top = s_r.cmpA;
        pwm = 1'b1;
      end
      default: begin
        top = `TBC_MAX;
      end
    endcase
    case (clkSel)
      tbc_pkg::TBC_CS_DIV1:   tick = 1'b1;
      tbc_pkg::TBC_CS_DIV8:   tick = ((s_r.presc & `TBC_PRE_DIV8) == `TBC_PRE_DIV8);
      tbc_pkg::TBC_CS_DIV64:  tick = ((s_r.presc & `TBC_PRE_DIV64) == `TBC_PRE_DIV64);
      tbc_pkg::TBC_CS_DIV256: tick = ((s_r.presc & `TBC_PRE_DIV256) == `TBC_PRE_DIV256);
      tbc_pkg::TBC_CS_DIV1K:  tick = (s_r.presc == `TBC_PRE_DIV1024);
      tbc_pkg::TBC_CS_EXTFAL: tick = extFall;
      tbc_pkg::TBC_CS_EXTRIS: tick = extRise;
      default:                tick = 1'b0;
    endcase
    wrap   = tick && (s_r.count == top);
    matchA = tick && (s_r.count == s_r.cmpA);
    matchB = tick && (s_r.count == s_r.cmpB);
    // capture input is shut off while the capture register is the ceiling
    capEvent = !capIsTop && (captureFromComparator ? cmpCap : pinCap);
  end

  // bus handshake and read mux
  always_comb begin
    wrGo  = s_r.awready && s_r.wready && s_axi_awvalid && s_axi_wvalid;
    rdGo  = s_r.arready && s_axi_arvalid;
    wByte = s_axi_wstrb[0] ? s_axi_wdata[7:0] : `TBC_RST_BYTE;
    rHit  = 1'b1;
    if (s_axi_araddr == `TBC_ADDR_CTRL_A) begin
      rByte = s_r.ctrlA;
    end else if (s_axi_araddr == `TBC_ADDR_CTRL_B) begin
      rByte = s_r.ctrlB;
    end else if (s_axi_araddr == `TBC_ADDR_CNT_LO) begin
      rByte = s_r.count[7:0];
    end else if (s_axi_araddr == `TBC_ADDR_CNT_HI) begin
      rByte = s_r.stage;
    end else if (s_axi_araddr == `TBC_ADDR_CAP_LO) begin
      rByte = s_r.capture[7:0];
    end else if (s_axi_araddr == `TBC_ADDR_CAP_HI) begin
      rByte = s_r.stage;
    end else if (s_axi_araddr == `TBC_ADDR_CMPA_LO) begin
      rByte = s_r.cmpABuf[7:0];
    end else if (s_axi_araddr == `TBC_ADDR_CMPA_HI) begin
      rByte = s_r.cmpABuf[15:8];
    end else if (s_axi_araddr == `TBC_ADDR_CMPB_LO) begin
      rByte = s_r.cmpBBuf[7:0];
    end else if (s_axi_araddr == `TBC_ADDR_CMPB_HI) begin
      rByte = s_r.cmpBBuf[15:8];
    end else if (s_axi_araddr == `TBC_ADDR_FLAG) begin
      rByte = s_r.flags;
    end else if (s_axi_araddr == `TBC_ADDR_MASK) begin
      rByte = s_r.mask;
    end else begin
      rByte = `TBC_RST_BYTE;
      rHit  = 1'b0;
    end
    wHit = (s_axi_awaddr <= `TBC_ADDR_MASK) && (s_axi_awaddr[1:0] == 2'h0);
  end

  // next state: counting first, then bus effects so a write wins
  always_comb begin
    s_nxt       = s_r;
    s_nxt.presc = s_r.presc + 10'h001;
    if (wrap) begin
      s_nxt.count = `TBC_FLOOR;
      if (pwm) begin
        // buffered compares take effect only at the period boundary
        s_nxt.cmpA = s_r.cmpABuf;
        s_nxt.cmpB = s_r.cmpBBuf;
      end
    end else if (tick) begin
      s_nxt.count = s_r.count + 16'h0001;
    end
    if (capEvent) begin
      s_nxt.capture = s_r.count;
    end
    // waveform outputs from the compare results
    case (s_r.ctrlA[`TBC_A_OUTA_MODE])
      `TBC_OUT_OFF: s_nxt.outA = 1'b0;
      `TBC_OUT_TOGGLE: begin
        if (matchA) s_nxt.outA = ~s_r.outA;
      end
      default: begin
        // channel A holds its level when it defines the ceiling
        if (pwm && mode != tbc_pkg::TBC_M_FPWM_A) begin
          if (wrap) s_nxt.outA = (s_r.ctrlA[`TBC_A_OUTA_MODE] == `TBC_OUT_PWM_NORM);
          else if (matchA) s_nxt.outA = (s_r.ctrlA[`TBC_A_OUTA_MODE] != `TBC_OUT_PWM_NORM);
        end
      end
    endcase
    case (s_r.ctrlA[`TBC_A_OUTB_MODE])
      `TBC_OUT_OFF: s_nxt.outB = 1'b0;
      `TBC_OUT_TOGGLE: begin
        if (matchB) s_nxt.outB = ~s_r.outB;
      end
      default: begin
        if (pwm) begin
          if (wrap) s_nxt.outB = (s_r.ctrlA[`TBC_A_OUTB_MODE] == `TBC_OUT_PWM_NORM);
          else if (matchB) s_nxt.outB = (s_r.ctrlA[`TBC_A_OUTB_MODE] != `TBC_OUT_PWM_NORM);
        end
      end
    endcase
    // write channel: both taken together, answer one cycle later
    s_nxt.awready = 1'b0;
    s_nxt.wready  = 1'b0;
    if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (!s_r.bvalid && !s_r.awready && s_axi_awvalid && s_axi_wvalid) begin
      s_nxt.awready = 1'b1;
      s_nxt.wready  = 1'b1;
    end
    if (wrGo) begin
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp  = wHit ? `TBC_RESP_OKAY : `TBC_RESP_SLVERR;
      if (s_axi_awaddr == `TBC_ADDR_CTRL_A) begin
        s_nxt.ctrlA = wByte;
      end else if (s_axi_awaddr == `TBC_ADDR_CTRL_B) begin
        s_nxt.ctrlB = wByte;
      end else if (s_axi_awaddr == `TBC_ADDR_CNT_HI || s_axi_awaddr == `TBC_ADDR_CAP_HI ||
                   s_axi_awaddr == `TBC_ADDR_CMPA_HI || s_axi_awaddr == `TBC_ADDR_CMPB_HI) begin
        s_nxt.stage = wByte;
      end else if (s_axi_awaddr == `TBC_ADDR_CNT_LO) begin
        s_nxt.count = {s_r.stage, wByte};
      end else if (s_axi_awaddr == `TBC_ADDR_CAP_LO) begin
        if (capIsTop) s_nxt.capture = {s_r.stage, wByte};
      end else if (s_axi_awaddr == `TBC_ADDR_CMPA_LO) begin
        s_nxt.cmpABuf = {s_r.stage, wByte};
        if (!pwm) s_nxt.cmpA = {s_r.stage, wByte};
      end else if (s_axi_awaddr == `TBC_ADDR_CMPB_LO) begin
        s_nxt.cmpBBuf = {s_r.stage, wByte};
        if (!pwm) s_nxt.cmpB = {s_r.stage, wByte};
      end else if (s_axi_awaddr == `TBC_ADDR_FLAG) begin
        s_nxt.flags = s_r.flags & ~wByte; // write one clears
      end else if (s_axi_awaddr == `TBC_ADDR_MASK) begin
        s_nxt.mask = wByte & `TBC_FLG_USED;
      end
    end
    // hardware set after the clear so an event in the clear cycle survives
    if (pwm ? wrap : (tick && s_r.count == `TBC_MAX)) s_nxt.flags[`TBC_FLG_OVF] = 1'b1;
    if (matchA) s_nxt.flags[`TBC_FLG_CMPA] = 1'b1;
    if (matchB) s_nxt.flags[`TBC_FLG_CMPB] = 1'b1;
    if (capEvent) s_nxt.flags[`TBC_FLG_CAP] = 1'b1;
    // read channel: one cycle ready pulse, data with rvalid next
    s_nxt.arready = 1'b0;
    if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
    if (!s_r.rvalid && !s_r.arready && s_axi_arvalid) begin
      s_nxt.arready = 1'b1;
    end
    if (rdGo) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata  = rByte;
      s_nxt.rresp  = rHit ? `TBC_RESP_OKAY : `TBC_RESP_SLVERR;
      // a counter or capture low-byte read arms the staging byte for the following high read
      if (s_axi_araddr == `TBC_ADDR_CNT_LO) begin
        s_nxt.stage = s_r.count[15:8];
      end else if (s_axi_araddr == `TBC_ADDR_CAP_LO) begin
        s_nxt.stage = s_r.capture[15:8];
      end
    end
    // requests gated per source, registered so outputs come from flops
    s_nxt.irq = {s_nxt.flags[`TBC_FLG_CAP], s_nxt.flags[`TBC_FLG_CMPB],
                 s_nxt.flags[`TBC_FLG_CMPA], s_nxt.flags[`TBC_FLG_OVF]} &
                {s_r.mask[`TBC_FLG_CAP], s_r.mask[`TBC_FLG_CMPB],
                 s_r.mask[`TBC_FLG_CMPA], s_r.mask[`TBC_FLG_OVF]};
    s_nxt.atFloor = (s_nxt.count == `TBC_FLOOR);
    s_nxt.atMax   = (s_nxt.count == `TBC_MAX);
    s_nxt.atTop   = (s_nxt.count == top);
  end

  // single state register; staging and all else clear on reset, except atFloor, which sets
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_r         <= '0;
      s_r.atFloor <= 1'b1;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign s_axi_awready = s_r.awready;
  assign s_axi_wready  = s_r.wready;
  assign s_axi_bvalid  = s_r.bvalid;
  assign s_axi_bresp   = s_r.bresp;
  assign s_axi_arready = s_r.arready;
  assign s_axi_rvalid  = s_r.rvalid;
  assign s_axi_rresp   = s_r.rresp;
  assign s_axi_rdata   = {24'h000000, s_r.rdata};
  assign compareOutA   = s_r.outA;
  assign compareOutB   = s_r.outB;
  assign irqReq        = s_r.irq;
  assign countFloor    = s_r.atFloor;
  assign countMax      = s_r.atMax;
  assign countTop      = s_r.atTop;

endmodule

`default_nettype wire

/* File: inc/tbc_defines.svh */
/*
  Constants for the 16-bit timer core: register word addresses,
  control field positions, flag bit positions, reset values and
  prescaler taps. Included by the timer package, which the design files use.
*/
`ifndef TBC_DEFINES_SVH
`define TBC_DEFINES_SVH

// byte addresses of the AXI4-Lite word slots, one 8-bit register each
`define TBC_ADDR_CTRL_A   8'h00
`define TBC_ADDR_CTRL_B   8'h04
`define TBC_ADDR_CNT_LO   8'h08
`define TBC_ADDR_CNT_HI   8'h0c
`define TBC_ADDR_CAP_LO   8'h10
`define TBC_ADDR_CAP_HI   8'h14
`define TBC_ADDR_CMPA_LO  8'h18
`define TBC_ADDR_CMPA_HI  8'h1c
`define TBC_ADDR_CMPB_LO  8'h20
`define TBC_ADDR_CMPB_HI  8'h24
`define TBC_ADDR_FLAG     8'h28
`define TBC_ADDR_MASK     8'h2c

// timer_control_a fields
`define TBC_A_MODE_LO     1:0
`define TBC_A_OUTB_MODE   5:4
`define TBC_A_OUTA_MODE   7:6
// timer_control_b fields
`define TBC_B_CLK_SEL     2:0
`define TBC_B_MODE_HI     4:3
`define TBC_B_CAP_RISE    6
`define TBC_B_CAP_FILTER  7

// flag and mask bit positions
`define TBC_FLG_OVF       0
`define TBC_FLG_CMPA      1
`define TBC_FLG_CMPB      2
`define TBC_FLG_CAP       5
`define TBC_FLG_USED      8'h27

// output pin modes
`define TBC_OUT_OFF       2'h0
`define TBC_OUT_TOGGLE    2'h1
`define TBC_OUT_PWM_NORM  2'h2

// counter landmarks
`define TBC_FLOOR         16'h0000
`define TBC_MAX           16'hffff
`define TBC_TOP_8BIT      16'h00ff
`define TBC_TOP_9BIT      16'h01ff
`define TBC_TOP_10BIT     16'h03ff

// prescaler taps: low bits all ones mark the tick of each divisor
`define TBC_PRE_DIV8      10'h007
`define TBC_PRE_DIV64     10'h03f
`define TBC_PRE_DIV256    10'h0ff
`define TBC_PRE_DIV1024   10'h3ff

// reset values and bus answers
`define TBC_RST_BYTE      8'h00
`define TBC_RST_WORD      16'h0000
`define TBC_RESP_OKAY     2'h0
`define TBC_RESP_SLVERR   2'h2
`define TBC_FILTER_LEN    4

`endif

/* File: inc/tbc_pkg.sv */
/*
  Types of the 16-bit timer core: mode and clock-select enumerations
  and the packed state of the core. Assumes tbc_defines.svh on the
  include path.
*/
`include "tbc_defines.svh"

package tbc_pkg;

  // counting sequence selected by the four mode bits
  typedef enum logic [3:0] {
    TBC_M_NORMAL  = 4'h0,
    TBC_M_PWM8    = 4'h1,
    TBC_M_PWM9    = 4'h2,
    TBC_M_PWM10   = 4'h3,
    TBC_M_CTC_A   = 4'h4,
    TBC_M_FPWM8   = 4'h5,
    TBC_M_FPWM9   = 4'h6,
    TBC_M_FPWM10  = 4'h7,
    TBC_M_CTC_CAP = 4'hc,
    TBC_M_FPWM_CAP = 4'he,
    TBC_M_FPWM_A  = 4'hf
  } tbc_mode_t;

  // tick source
  typedef enum logic [2:0] {
    TBC_CS_STOP   = 3'h0,
    TBC_CS_DIV1   = 3'h1,
    TBC_CS_DIV8   = 3'h2,
    TBC_CS_DIV64  = 3'h3,
    TBC_CS_DIV256 = 3'h4,
    TBC_CS_DIV1K  = 3'h5,
    TBC_CS_EXTFAL = 3'h6,
    TBC_CS_EXTRIS = 3'h7
  } tbc_clksel_t;

  // whole state of the core, registered in one process
  typedef struct packed {
    logic [7:0]  ctrlA;
    logic [7:0]  ctrlB;
    logic [15:0] count;
    logic [15:0] capture;
    logic [15:0] cmpA;
    logic [15:0] cmpB;
    logic [15:0] cmpABuf;
    logic [15:0] cmpBBuf;
    logic [7:0]  stage;
    logic [7:0]  flags;
    logic [7:0]  mask;
    logic [9:0]  presc;
    logic        outA;
    logic        outB;
    logic [3:0]  irq;
    logic        atFloor;
    logic        atMax;
    logic        atTop;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [7:0]  rdata;
  } tbc_state_t;

endpackage

/* File: hw/tbc_pin_edge.sv */
/*
  Pin front end: two-flop synchroniser, optional four-sample noise
  filter and edge detector giving a one-cycle pulse on the chosen edge.
  Assumes the pin is asynchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none

module tbc_pin_edge (
  input  wire logic clk,
  input  wire logic reset_n,
  input  wire logic pinIn,
  input  wire logic filterEn,
  input  wire logic riseSel,
  output logic      edgePulse
);

  typedef struct packed {
    logic       sync1;
    logic       sync2;
    logic [2:0] hist;
    logic       level;
    logic       levelDly;
    logic       pulse;
  } tbc_pin_state_t;

  tbc_pin_state_t s_r;
  tbc_pin_state_t s_nxt;
  logic           allSame;

  // the filter only passes a level after four equal samples, which
  // costs three extra cycles of delay but rejects short spikes
  always_comb begin
    s_nxt       = s_r;
    s_nxt.sync1 = pinIn;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.hist  = {s_r.hist[1:0], s_r.sync2};
    allSame     = (s_r.hist == {3{s_r.sync2}});
    if (!filterEn || allSame) begin
      s_nxt.level = s_r.sync2;
    end
    s_nxt.levelDly = s_r.level;
    s_nxt.pulse    = riseSel ? (s_r.level & ~s_r.levelDly)
                             : (~s_r.level & s_r.levelDly);
  end

  // synchronous reset, constants only
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign edgePulse = s_r.pulse;

endmodule

`default_nettype wire

/* File: dv/tbc_core_props.sv */
/*
  Bus and counter landmark checks for the timer core, bound to its ports.
  Assumes one clock and the synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tbc_core_props (
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        countFloor,
  input wire logic        countMax,
  input wire logic        countTop,
  input wire logic [3:0]  irqReq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  // write pair is taken together, one cycle after both valids
  a_pair_ready: assert property (s_axi_awready == s_axi_wready)
    else $error("write address and data ready differ");
  a_wr_accept: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid
    |=> s_axi_awready)
    else $error("write pair not taken");
  a_wr_answer: assert property (s_axi_awready |=> s_axi_bvalid && !s_axi_awready)
    else $error("write answer late");
  a_rd_accept: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
    |=> s_axi_arready)
    else $error("read not taken");
  a_rd_answer: assert property (s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  // answers stand until the cpu takes them
  a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_byte_wide: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data wider than a byte");
  // landmarks: floor and max never together, leaving the ceiling means a wrap
  a_floor_max: assert property (!(countFloor && countMax))
    else $error("floor and max together");
  a_top_wraps: assert property (countTop ##1 !countTop |-> countFloor)
    else $error("left the ceiling without wrapping");

  cover property (countMax ##1 countFloor);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property (irqReq[2] && irqReq[3]);
endmodule

bind tbc_core tbc_core_props i_props (.*);
`default_nettype wire

/* File: dv/tbc_cpu_model.sv */
/*
  Cpu side model: byte-wide AXI4-Lite master, one access at a time.
  Assumes the slave answers every accepted request.
*/
`timescale 1ns/1ps
`default_nettype none
module tbc_cpu_model (
  input  wire logic   clk,
  output logic [7:0]  s_axi_awaddr,
  output logic        s_axi_awvalid,
  input  wire logic   s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0]  s_axi_wstrb,
  output logic        s_axi_wvalid,
  input  wire logic   s_axi_wready,
  input  wire logic   s_axi_bvalid,
  output logic        s_axi_bready,
  output logic [7:0]  s_axi_araddr,
  output logic        s_axi_arvalid,
  input  wire logic   s_axi_arready,
  input  wire logic   s_axi_rvalid,
  output logic        s_axi_rready
);
  // idle bus; only lane 0 carries a byte
  initial begin
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'h1;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
  end

  // byte write, never interleaved with another access; gaps make the cpu slow at times
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    repeat ($urandom_range(2)) @(posedge clk);
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do @(posedge clk); while (!(s_axi_awready && s_axi_wready));
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_awaddr <= ~a; // released lines must not keep the old value
    s_axi_wdata <= ~{24'h0, d};
    do @(posedge clk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  // byte read; the bench watches the answer itself
  task automatic rd(input logic [7:0] a);
    repeat ($urandom_range(2)) @(posedge clk);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    s_axi_araddr <= ~a;
    do @(posedge clk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: dv/tb.sv */
/*
  Self-checking bench for the timer core: byte-wide register traffic,
  counting, compare, capture and landmark outputs.
  Assumes the cpu model and checker files compile first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        clk;
  logic        reset_n;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, irqReq;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        extCountPin, capturePin, comparatorOut, captureFromComparator;
  logic        compareOutA, compareOutB, countFloor, countMax, countTop;
  logic [10:0] rq[$];
  logic [1:0]  wq[$];
  logic [10:0] e;
  logic [31:0] r;
  logic [15:0] v;
  int          num_errors = 0;
  int          checks_done = 0;

  tbc_core i_dut (.*);
  tbc_cpu_model i_cpu (.*);

  // 40 MHz clock
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic results();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] g);
    checks_done++;
    if (g !== x) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask

  // expected answers are noted before each access; slots past the map are refused
  task automatic wb(input logic [7:0] a, input logic [7:0] d);
    wq.push_back((a > 8'h2c) ? 2'h2 : 2'h0);
    i_cpu.wr(a, d);
  endtask
  task automatic rb(input logic [7:0] a, input logic [7:0] d, input logic c);
    rq.push_back({c, ((a > 8'h2c) ? 2'h2 : 2'h0), d});
    i_cpu.rd(a);
  endtask
  task automatic w16(input logic [7:0] a, input logic [15:0] x);
    wb(a + 8'h4, x[15:8]);
    wb(a, x[7:0]);
  endtask
  task automatic r16(input logic [7:0] a, input logic [15:0] x);
    rb(a, x[7:0], 1'b1);
    rb(a + 8'h4, x[15:8], 1'b1);
  endtask
  // bounded wait for a level, a miss counts as a mismatch
  task automatic till(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 400) begin
      @(posedge clk);
      n++;
    end
    chk("wait", 16'(n < 400), 16'h1);
  endtask

  // answer monitor: oldest note against each answer as it is taken
  always @(posedge clk) begin
    if (s_axi_rvalid && s_axi_rready) begin
      e = rq.pop_front();
      if (e[10]) chk("rdata", {6'h0, e[9:0]}, {6'h0, s_axi_rresp, s_axi_rdata[7:0]});
    end
    if (s_axi_bvalid && s_axi_bready) chk("bresp", {14'h0, wq.pop_front()}, {14'h0, s_axi_bresp});
  end

  // hang guard, far beyond the fewer than a thousand cycles the tests need
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    results();
  end

  initial begin
    void'($urandom(88827));
    extCountPin = 1'b0;
    capturePin = 1'b0;
    comparatorOut = 1'b0;
    captureFromComparator = 1'b0;
    reset_n = 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    // every slot reads zero after reset, the one past the map is refused
    for (int a = 0; a <= 'h30; a += 4) rb(8'(a), 8'h00, 1'b1);
    wb(8'h30, 8'h5a);
    // control bytes take direct single accesses, clock kept stopped
    r = $urandom();
    wb(8'h00, r[7:0] & 8'hf3);
    wb(8'h04, r[15:8] & 8'hd8);
    rb(8'h00, r[7:0] & 8'hf3, 1'b1);
    rb(8'h04, r[15:8] & 8'hd8, 1'b1);
    wb(8'h00, 8'h00);
    wb(8'h04, 8'h00);
    // counter round trip, then one staged byte serves two compares
    v = {1'b0, r[30:16]};
    w16(8'h08, v);
    r16(8'h08, v);
    wb(8'h1c, 8'h80);
    wb(8'h18, 8'h11);
    wb(8'h20, 8'h22);
    r16(8'h18, 16'h8011);
    r16(8'h20, 16'h8022);
    // compare high read bypasses the staged counter byte
    rb(8'h08, v[7:0], 1'b1);
    rb(8'h1c, 8'h80, 1'b1);
    rb(8'h0c, v[15:8], 1'b1);
    // capture writes land only when capture is the ceiling
    w16(8'h10, 16'hbeef);
    r16(8'h10, 16'h0000);
    wb(8'h04, 8'h18);
    w16(8'h10, 16'hbeef);
    r16(8'h10, 16'hbeef);
    wb(8'h04, 8'h00);
    // run through max to floor, overflow flag and its mask
    w16(8'h08, 16'hff00);
    wb(8'h2c, 8'hff);
    rb(8'h2c, 8'h27, 1'b1);
    wb(8'h04, 8'h01);
    till(countMax);
    @(posedge clk);
    chk("countFloor", 16'(countFloor), 16'h1);
    wb(8'h04, 8'h00);
    chk("irqReq", 16'(irqReq), 16'h1);
    rb(8'h28, 8'h01, 1'b1);
    wb(8'h28, 8'h01);
    chk("irqReq", 16'(irqReq), 16'h0);
    // compare B match toggles its pin, a rising capture edge stores the count
    w16(8'h08, 16'h1230);
    w16(8'h20, 16'h1240);
    wb(8'h00, 8'h10);
    wb(8'h04, 8'h41);
    repeat (8) @(posedge clk);
    capturePin <= 1'b1;
    repeat (12) @(posedge clk);
    wb(8'h04, 8'h40);
    rb(8'h28, 8'h24, 1'b1);
    chk("irqReq", 16'(irqReq), 16'hc);
    chk("compareOutB", 16'(compareOutB), 16'h1);
    chk("compareOutA", 16'(compareOutA), 16'h0);
    rb(8'h10, 8'h00, 1'b0);
    rb(8'h14, 8'h12, 1'b1);
    wb(8'h28, 8'hff);
    // fixed ceiling 0x00ff wraps to floor; the wrap sets pin A, clears inverted pin B
    wb(8'h00, 8'hb1);
    w16(8'h08, 16'h00f0);
    wb(8'h04, 8'h01);
    till(countTop);
    @(posedge clk);
    chk("countFloor", 16'(countFloor), 16'h1);
    chk("compareOutA", 16'(compareOutA), 16'h1);
    chk("compareOutB", 16'(compareOutB), 16'h0);
    wb(8'h04, 8'h00);
    // three rising edges on the count pin give three counts
    wb(8'h00, 8'h00);
    w16(8'h08, 16'h0000);
    wb(8'h04, 8'h07);
    repeat (3) begin
      extCountPin <= 1'b1;
      repeat (4) @(posedge clk);
      extCountPin <= 1'b0;
      repeat (4) @(posedge clk);
    end
    repeat (4) @(posedge clk);
    wb(8'h04, 8'h00);
    r16(8'h08, 16'h0003);
    // comparator as capture source with filter: a short spike is dropped
    wb(8'h28, 8'hff);
    captureFromComparator <= 1'b1;
    wb(8'h04, 8'hc0);
    comparatorOut <= 1'b1;
    repeat (2) @(posedge clk);
    comparatorOut <= 1'b0;
    repeat (10) @(posedge clk);
    rb(8'h28, 8'h00, 1'b1);
    comparatorOut <= 1'b1;
    repeat (12) @(posedge clk);
    rb(8'h28, 8'h20, 1'b1);
    chk("irqReq", 16'(irqReq), 16'h8);
    rb(8'h10, 8'h03, 1'b1);
    repeat (4) @(posedge clk);
    results();
  end
endmodule
`default_nettype wire
